// [rtl/frs_sequencer.v]
`include "frs_defs.vh"
module frs_sequencer #(
  parameter TICK_CYCLES = `FRS_TICK_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        por_i,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        oc_fault_i,
  input  wire        ov_fault_i,
  input  wire        uv_fault_i,
  input  wire        phase_loss_i,
  input  wire        stopping_i,
  input  wire [15:0] motor_freq_i,
  input  wire [15:0] run_freq_i,
  output reg         output_enable_o,
  output reg  [15:0] start_freq_o,
  output reg         restart_o,
  output reg         decel_stop_o,
  output reg         alarm_o,
  output reg         locked_o,
  output reg  [3:0]  trip_cause_o
);
  // states, one-hot
  localparam [5:0] ST_RUN    = 6'h01;
  localparam [5:0] ST_FAULT  = 6'h02;
  localparam [5:0] ST_WAIT   = 6'h04;
  localparam [5:0] ST_START  = 6'h08;
  localparam [5:0] ST_ALARM  = 6'h10;
  localparam [5:0] ST_LOCKED = 6'h20;

  // configuration registers
  reg [1:0]  restart_method_select;    // restart method code
  reg [1:0]  power_fail_trip_enable;   // uv alarm code
  reg        undervoltage_retry_limit; // 1 = unlimited
  reg        phase_loss_detect_enable; // phase loss trip on
  reg [15:0] undervoltage_allow_time;  // tenths of second
  reg [15:0] restart_wait_time;        // tenths of second
  reg [15:0] restart_freq_threshold;   // hundredths of hz

  // sequencer state
  reg [5:0]  state;
  reg [3:0]  cause;      // {ph, uv, ov, oc}
  reg [4:0]  oc_count;   // retry counters
  reg [4:0]  ov_count;
  reg [4:0]  uv_count;
  reg [15:0] timer;      // tenths counter
  reg [15:0] prev_freq;  // frequency before trip

  // synchronised fault pins
  wire oc_s;
  wire ov_s;
  wire uv_s;
  wire ph_s;
  wire tick;

  frs_sync u_oc (.clk_i(clk_i), .rst_i(rst_i), .d_i(oc_fault_i), .q_o(oc_s));
  frs_sync u_ov (.clk_i(clk_i), .rst_i(rst_i), .d_i(ov_fault_i), .q_o(ov_s));
  frs_sync u_uv (.clk_i(clk_i), .rst_i(rst_i), .d_i(uv_fault_i), .q_o(uv_s));
  frs_sync u_ph (.clk_i(clk_i), .rst_i(rst_i), .d_i(phase_loss_i), .q_o(ph_s));
  frs_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (.clk_i(clk_i), .rst_i(rst_i), .tick_o(tick));

  // clamp a setting into its documented range
  // out-of-range writes are pulled to the nearest legal value, not refused
  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // bus decode
  // the ~ack term keeps a held request from being taken twice
  wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0] addr   = wb_adr_i[7:0];
  wire       wr     = wb_req & wb_we_i & wb_sel_i[0];

  // uv counts as a trip source depending on alarm code
  wire uv_trip_en = (power_fail_trip_enable == `FRS_PFTRIP_ON) |
                    ((power_fail_trip_enable == `FRS_PFTRIP_RUNONLY) & ~stopping_i);
  wire uv_event   = uv_s & uv_trip_en;
  wire ph_event   = ph_s & phase_loss_detect_enable;
  wire any_fault  = oc_s | ov_s | uv_event | ph_event;

  // retry allowed for the captured cause
  // limits are checked on the next trip, so three means three restarts
  wire oc_ok = oc_count < `FRS_OC_LIMIT;
  wire ov_ok = ov_count < `FRS_OV_LIMIT;
  wire uv_ok = undervoltage_retry_limit | (uv_count < `FRS_UV_LIMIT);
  wire retry_ok = ~cause[3] & (~cause[0] | oc_ok) & (~cause[1] | ov_ok) & (~cause[2] | uv_ok);

  // start frequency choice
  // a slow rotor is not worth matching; it starts from zero instead
  wire below_thr = motor_freq_i < restart_freq_threshold;

  // register writes and bus answer
  always @(posedge clk_i) begin
    if (rst_i) begin
      restart_method_select    <= `FRS_METHOD_ALARM;
      power_fail_trip_enable   <= `FRS_PFTRIP_OFF;
      undervoltage_retry_limit <= 1'b0;
      phase_loss_detect_enable <= 1'b0;
      undervoltage_allow_time  <= `FRS_UV_TIME_RST;
      restart_wait_time        <= `FRS_WAIT_RST;
      restart_freq_threshold   <= `FRS_FTHR_RST;
      wb_ack_o                 <= 1'b0;
      wb_dat_o                 <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wr) begin
        case (addr)
          `FRS_REG_CTRL: begin
            restart_method_select    <= wb_dat_i[`FRS_CTRL_METHOD_LO+1:`FRS_CTRL_METHOD_LO];
            // code 3 is reserved; treat as off
            power_fail_trip_enable   <= (wb_dat_i[`FRS_CTRL_PFTRIP_LO+1:`FRS_CTRL_PFTRIP_LO] == 2'h3) ?
                                        `FRS_PFTRIP_OFF : wb_dat_i[`FRS_CTRL_PFTRIP_LO+1:`FRS_CTRL_PFTRIP_LO];
            undervoltage_retry_limit <= wb_dat_i[`FRS_CTRL_UVLIM_BIT];
            phase_loss_detect_enable <= wb_dat_i[`FRS_CTRL_PHLOSS_BIT];
          end
          `FRS_REG_UV_TIME: begin
            if (wb_sel_i[1]) begin
              undervoltage_allow_time <= clamp16(wb_dat_i[15:0], `FRS_UV_TIME_MIN, `FRS_UV_TIME_MAX);
            end
          end
          `FRS_REG_WAIT_TIME: begin
            if (wb_sel_i[1]) begin
              restart_wait_time <= clamp16(wb_dat_i[15:0], `FRS_WAIT_MIN, `FRS_WAIT_MAX);
            end
          end
          `FRS_REG_FREQ_THR: begin
            if (wb_sel_i[1]) begin
              restart_freq_threshold <= clamp16(wb_dat_i[15:0], 16'h0000, `FRS_FTHR_MAX);
            end
          end
          default: begin
            // read-only or unmapped: write ignored, still acked
          end
        endcase
      end
      // read mux; unmapped reads zero
      case (addr)
        `FRS_REG_CTRL:      wb_dat_o <= {26'h0, phase_loss_detect_enable, undervoltage_retry_limit,
                                         power_fail_trip_enable, restart_method_select};
        `FRS_REG_UV_TIME:   wb_dat_o <= {16'h0, undervoltage_allow_time};
        `FRS_REG_WAIT_TIME: wb_dat_o <= {16'h0, restart_wait_time};
        `FRS_REG_FREQ_THR:  wb_dat_o <= {16'h0, restart_freq_threshold};
        `FRS_REG_STATUS:    wb_dat_o <= {22'h0, cause, state};
        `FRS_REG_COUNTS:    wb_dat_o <= {17'h0, uv_count, ov_count, oc_count};
        `FRS_REG_FREQ_OUT:  wb_dat_o <= {16'h0, start_freq_o};
        default:            wb_dat_o <= 32'h0;
      endcase
    end
  end

  // retry counters: only power-on reset clears them, not rst_i
  always @(posedge clk_i) begin
    if (por_i) begin
      oc_count <= 5'h0;
      ov_count <= 5'h0;
      uv_count <= 5'h0;
    end else if ((state == ST_WAIT) && !any_fault && (timer >= restart_wait_time) && tick) begin
      // one attempt counted per restart
      // counts saturate so an unlimited run can never wrap under a limit
      if (cause[0] && oc_count != 5'h1f) begin
        oc_count <= oc_count + 5'h1;
      end
      if (cause[1] && ov_count != 5'h1f) begin
        ov_count <= ov_count + 5'h1;
      end
      if (cause[2] && uv_count != 5'h1f) begin
        uv_count <= uv_count + 5'h1;
      end
    end
  end

  // sequencer
  always @(posedge clk_i) begin
    if (por_i || (rst_i && (state != ST_LOCKED))) begin
      state           <= ST_RUN;
      cause           <= 4'h0;
      timer           <= 16'h0;
      prev_freq       <= 16'h0;
      output_enable_o <= 1'b0;
      start_freq_o    <= 16'h0;
      restart_o       <= 1'b0;
      decel_stop_o    <= 1'b0;
      alarm_o         <= 1'b0;
      locked_o        <= 1'b0;
      trip_cause_o    <= 4'h0;
    end else if (rst_i) begin
      // a controller reset leaves an exhausted lock in place;
      // releasing it here would let a stuck fault keep retrying
      restart_o       <= 1'b0;
      output_enable_o <= 1'b0;
    end else begin
      restart_o <= 1'b0;
      case (state)
        ST_RUN: begin
          output_enable_o <= 1'b1;
          prev_freq       <= run_freq_i;
          timer           <= 16'h0;
          if (any_fault) begin
            cause           <= {ph_event, uv_event, ov_s, oc_s};
            trip_cause_o    <= {ph_event, uv_event, ov_s, oc_s};
            output_enable_o <= 1'b0;
            decel_stop_o    <= 1'b0;
            state           <= ST_FAULT;
          end
        end
        ST_FAULT: begin
          // time the fault; long under-voltage trips outright
          if (tick && timer != 16'hffff) begin
            timer <= timer + 16'h1;
          end
          // method first: code 00 never restarts, whatever the counters say
          if (restart_method_select == `FRS_METHOD_ALARM) begin
            alarm_o <= 1'b1;
            state   <= ST_ALARM;
          end else if (!retry_ok) begin
            alarm_o  <= 1'b1;
            locked_o <= 1'b1;
            state    <= ST_LOCKED;
          end else if (cause[2] && timer > undervoltage_allow_time) begin
            alarm_o <= 1'b1;
            state   <= ST_ALARM;
          end else if (!any_fault) begin
            timer <= 16'h0;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // delay counted from fault clearing; re-fault restarts timing
          if (any_fault) begin
            timer <= 16'h0;
            cause <= cause | {ph_event, uv_event, ov_s, oc_s};
            state <= ST_FAULT;
          end else if (tick) begin
            if (timer >= restart_wait_time) begin
              state <= ST_START;
            end else begin
              timer <= timer + 16'h1;
            end
          end
        end
        ST_START: begin
          // pick starting frequency
          if (restart_method_select == `FRS_METHOD_ZERO || below_thr) begin
            start_freq_o <= 16'h0;
          end else if (restart_method_select == `FRS_METHOD_PREV) begin
            start_freq_o <= prev_freq;
            decel_stop_o <= 1'b1;
            alarm_o      <= 1'b1;
          end else begin
            start_freq_o <= motor_freq_i;
          end
          restart_o       <= 1'b1;
          output_enable_o <= 1'b1;
          state           <= ST_RUN;
        end
        ST_ALARM: begin
          // tripped; cleared by rst_i
          output_enable_o <= 1'b0;
        end
        ST_LOCKED: begin
          // only power-up releases this
          output_enable_o <= 1'b0;
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end
endmodule

// [rtl/frs_defs.vh]
`ifndef FRS_DEFS_VH
`define FRS_DEFS_VH
// register byte offsets (wishbone word aligned)
`define FRS_REG_CTRL        8'h00
`define FRS_REG_UV_TIME     8'h04
`define FRS_REG_WAIT_TIME   8'h08
`define FRS_REG_FREQ_THR    8'h0c
`define FRS_REG_STATUS      8'h10
`define FRS_REG_COUNTS      8'h14
`define FRS_REG_FREQ_OUT    8'h18
// ctrl field positions
`define FRS_CTRL_METHOD_LO  0
`define FRS_CTRL_PFTRIP_LO  2
`define FRS_CTRL_UVLIM_BIT  4
`define FRS_CTRL_PHLOSS_BIT 5
// option codes
`define FRS_METHOD_ALARM    2'h0
`define FRS_METHOD_ZERO     2'h1
`define FRS_METHOD_MATCH    2'h2
`define FRS_METHOD_PREV     2'h3
`define FRS_PFTRIP_OFF      2'h0
`define FRS_PFTRIP_ON       2'h1
`define FRS_PFTRIP_RUNONLY  2'h2
// retry limits
`define FRS_OC_LIMIT        5'h03
`define FRS_OV_LIMIT        5'h03
`define FRS_UV_LIMIT        5'h10
// times in tenths of a second / hundredths of hz
`define FRS_UV_TIME_MIN     16'h0003
`define FRS_UV_TIME_MAX     16'h00fa
`define FRS_UV_TIME_RST     16'h000a
`define FRS_WAIT_MIN        16'h0003
`define FRS_WAIT_MAX        16'h03e8
`define FRS_WAIT_RST        16'h000a
`define FRS_FTHR_MAX        16'h9c40
`define FRS_FTHR_RST        16'h0000
// 0.1 s at 100 MHz = 10 ns period
`define FRS_TICK_NS         100000000
`define FRS_CLK_NS          10
`define FRS_TICK_CYCLES     (`FRS_TICK_NS / `FRS_CLK_NS)
`endif

// [rtl/frs_tick.v]
`include "frs_defs.vh"
// one-cycle pulse every tenth of a second
module frs_tick #(
  parameter TICK_CYCLES = `FRS_TICK_CYCLES
) (
  input  wire clk_i,
  input  wire rst_i,
  output reg  tick_o
);
  reg [31:0] count; // cycle counter

  // free-running divider
  always @(posedge clk_i) begin
    if (rst_i) begin
      count  <= 32'h0;
      tick_o <= 1'b0;
    end else if (count >= TICK_CYCLES - 1) begin
      count  <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// [rtl/frs_sync.v]
// three-flop synchroniser; output changes when stages two and three agree
module frs_sync (
  input  wire clk_i,
  input  wire rst_i,
  input  wire d_i,
  output reg  q_o
);
  reg s1; // metastable stage, read only by s2
  reg s2;
  reg s3;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1  <= 1'b0;
      s2  <= 1'b0;
      s3  <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end
endmodule

// [test/frs_seq_props.sv]
module frs_seq_props #(
  parameter TICK_CYCLES = 10
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        por_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire        oc_fault_i,
  input wire        ov_fault_i,
  input wire        output_enable_o,
  input wire        restart_o,
  input wire        decel_stop_o,
  input wire        alarm_o,
  input wire        locked_o
);
  localparam int MINW = 3 * TICK_CYCLES; // shortest legal wait in cycles
  logic [15:0] off_cnt;                  // cycles with output off
  // saturating count, so a long alarm cannot wrap it
  always_ff @(posedge clk_i) begin
    if (rst_i || output_enable_o) begin
      off_cnt <= 16'h0000;
    end else if (off_cnt != 16'hffff) begin
      off_cnt <= off_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_fault_held;
    (oc_fault_i || ov_fault_i) [*8];
  endsequence
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_follows:
    assert property (s_req |=> wb_ack_o) else $error("ack not one cycle after request");
  chk_restart_pulse:
    assert property (restart_o |=> !restart_o) else $error("restart pulse too long");
  chk_restart_wait:
    assert property (restart_o |-> off_cnt >= MINW) else $error("restart before wait elapsed");
  chk_wait_dark:
    assert property ($fell(output_enable_o) && !$past(rst_i) && !$past(por_i) |=> !output_enable_o [*8])
      else $error("output back too soon");
  chk_locked_hold:
    assert property (locked_o |=> locked_o) else $error("lock released without reset");
  chk_locked_dark:
    assert property (locked_o |-> !output_enable_o && !restart_o) else $error("output while locked");
  chk_alarm_quiet:
    assert property (alarm_o && !decel_stop_o |-> !restart_o) else $error("restart during alarm");
  chk_fault_drop:
    assert property (s_fault_held |-> !output_enable_o) else $error("output kept during fault");
endmodule
bind frs_sequencer frs_seq_props #(.TICK_CYCLES(TICK_CYCLES)) u_frs_seq_props (
  .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .oc_fault_i(oc_fault_i), .ov_fault_i(ov_fault_i),
  .output_enable_o(output_enable_o), .restart_o(restart_o), .decel_stop_o(decel_stop_o),
  .alarm_o(alarm_o), .locked_o(locked_o));

// [test/frs_sequencer_tb_top.sv]
`include "frs_defs.vh"
module frs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        por_i = 1'b1;
  logic [31:0] adr   = 32'h0;
  logic [31:0] wdat  = 32'h0;
  logic        we    = 1'b0;
  logic        cyc   = 1'b0;
  logic [3:0]  flt   = 4'h0;     // {phase, uv, ov, oc}
  logic [15:0] mfreq = 16'h04d2; // motor speed, 12.34 Hz
  logic [15:0] rfreq = 16'h0bb8; // run frequency, 30.00 Hz
  logic        stop  = 1'b0;     // drive stopped or ramping down
  wire  [3:0]  tcause;           // captured trip cause
  wire  [31:0] rdat;
  wire         ack, oen, rs, dec, alm, lck;
  wire  [15:0] sfreq;
  integer      bad_count = 0;
  integer      cmp_count = 0;
  integer      cyc_n     = 0;
  integer      n, i;
  logic [31:0] rv;
  always #5 clk_i = ~clk_i;
  frs_sequencer #(.TICK_CYCLES(10)) u_frs_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
    .wb_ack_o(ack), .oc_fault_i(flt[0]), .ov_fault_i(flt[1]), .uv_fault_i(flt[2]),
    .phase_loss_i(flt[3]), .stopping_i(stop), .motor_freq_i(mfreq), .run_freq_i(rfreq),
    .output_enable_o(oen), .start_freq_o(sfreq), .restart_o(rs), .decel_stop_o(dec),
    .alarm_o(alm), .locked_o(lck), .trip_cause_o(tcause));
  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input [31:0] seen, input [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input [7:0] a, input [31:0] d, input logic w);
    @(posedge clk_i);
    adr  <= {24'h0, a};
    wdat <= d;
    we   <= w;
    cyc  <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [31:0] exp);
    wb(a, 32'h0, 1'b0);
    check(rv, exp, "register");
  endtask
  // fault for len cycles, then n = cycles until restart (200 = none)
  task automatic trip(input [3:0] f, input integer len);
    repeat (4) @(posedge clk_i);
    flt <= f;
    repeat (len) @(posedge clk_i);
    flt <= 4'h0;
    n = 0;
    while (rs !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic pulse_rst;
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic pulse_por;
    @(posedge clk_i);
    por_i <= 1'b1;
    @(posedge clk_i);
    por_i <= 1'b0;
  endtask
  // hang guard, well above the longest run
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    rd(`FRS_REG_CTRL, 32'h0);
    rd(`FRS_REG_UV_TIME, 32'h0a);
    rd(`FRS_REG_WAIT_TIME, 32'h0a);
    rd(`FRS_REG_FREQ_THR, 32'h0);
    rd(8'h1c, 32'h0);
    wb(`FRS_REG_UV_TIME, 32'h12c, 1'b1);
    rd(`FRS_REG_UV_TIME, 32'hfa);
    wb(`FRS_REG_WAIT_TIME, 32'h1, 1'b1);
    rd(`FRS_REG_WAIT_TIME, 32'h3);
    // uv and phase loss both disabled by default: no reaction
    trip(4'hc, 10);
    check(n, 200, "no restart");
    check(alm, 1'b0, "alarm");
    // zero-speed restarts until the oc limit
    wb(`FRS_REG_CTRL, 32'h1, 1'b1);
    for (i = 0; i < 3; i++) begin
      trip(4'h1, 10);
      check(n >= 30 && n < 200, 1'b1, "oc restart");
      check(sfreq, 16'h0, "zero start");
    end
    trip(4'h1, 10);
    check(lck, 1'b1, "oc lock");
    rd(`FRS_REG_COUNTS, 32'h3);
    pulse_rst;
    rd(`FRS_REG_COUNTS, 32'h3);
    check(lck, 1'b1, "lock kept");
    check(oen, 1'b0, "dark lock");
    pulse_por;
    // uv ignored while stopping under code 02
    wb(`FRS_REG_CTRL, 32'h9, 1'b1);
    check(lck, 1'b0, "lock freed");
    stop <= 1'b1;
    trip(4'h4, 10);
    check(n, 200, "uv stopping");
    stop <= 1'b0;
    // unlimited uv retries pass sixteen; the limit code then locks
    wb(`FRS_REG_CTRL, 32'h15, 1'b1);
    wb(`FRS_REG_WAIT_TIME, 32'h1, 1'b1);
    wb(`FRS_REG_UV_TIME, 32'h1, 1'b1);
    for (i = 0; i < 17; i++) begin
      trip(4'h4, 10);
      check(n < 200, 1'b1, "uv retry");
    end
    wb(`FRS_REG_CTRL, 32'h5, 1'b1);
    trip(4'h4, 10);
    check(lck, 1'b1, "uv lock");
    pulse_por;
    // long uv trips
    trip(4'h4, 80);
    check(n, 200, "uv long");
    check(alm, 1'b1, "uv alarm");
    pulse_rst;
    // matched restarts, one below threshold, then ov lock
    wb(`FRS_REG_CTRL, 32'h2, 1'b1);
    wb(`FRS_REG_WAIT_TIME, 32'h1, 1'b1);
    wb(`FRS_REG_FREQ_THR, 32'h3e8, 1'b1);
    for (i = 0; i < 3; i++) begin
      mfreq <= (i == 1) ? 16'h01f4 : 16'h04d2;
      trip(4'h2, 10);
      check(sfreq, (i == 1) ? 16'h0 : 16'h04d2, "match start");
    end
    trip(4'h2, 10);
    check(lck, 1'b1, "ov lock");
    rd(`FRS_REG_COUNTS, 32'h60);
    pulse_por;
    rd(`FRS_REG_COUNTS, 32'h0);
    // resume previous frequency, then stop and report
    wb(`FRS_REG_CTRL, 32'h3, 1'b1);
    wb(`FRS_REG_WAIT_TIME, 32'h1, 1'b1);
    trip(4'h1, 10);
    check(sfreq, rfreq, "prev start");
    repeat (3) @(posedge clk_i);
    check({dec, alm}, 2'h3, "decel report");
    pulse_rst;
    // alarm-only method with phase loss enabled
    wb(`FRS_REG_CTRL, 32'h20, 1'b1);
    trip(4'h8, 10);
    check(n, 200, "no restart");
    check(alm, 1'b1, "phase alarm");
    check(tcause, 4'h8, "trip cause");
    rd(`FRS_REG_STATUS, 32'h210);
    report_and_stop;
  end
endmodule
